// file: rtl/fsp_host.sv
// Host bus controller for a bottom-boot parallel flash: reads, unlocked writes,
// identification reads. Assumes the flash pins sit on the far side of the ports.
`timescale 1ns/100ps
module fsp_host
  import fsp_pkg::*;
#(
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        srst,
  // Request side
  input  wire logic                        reqValid,
  input  wire fsp_pkg::fsp_op_t            reqOp,
  input  wire logic [fsp_pkg::ADDR_W-1:0]  reqAddr,
  input  wire logic [fsp_pkg::DATA_W-1:0]  reqData,
  input  wire logic                        reqIdHv,
  input  wire logic                        reqRstHv,
  output logic                             reqReady,
  output logic                             rspValid,
  output logic [fsp_pkg::DATA_W-1:0]       rspData,
  output logic [fsp_pkg::SECT_W-1:0]       rspSector,
  output logic                             rspProtected,
  // Flash pins
  output logic                             flashCeN,
  output logic                             flashOeN,
  output logic                             flashWeN,
  output logic [fsp_pkg::ADDR_W-1:0]       flashAddr,
  output logic                             flashIdHv,
  output logic                             flashRstHv,
  output logic [fsp_pkg::DATA_W-1:0]       flashDqOut,
  output logic                             flashDqOe,
  input  wire logic [fsp_pkg::DATA_W-1:0]  flashDqIn
);
  import fsp_pkg::*;

  typedef struct packed {
    fsp_state_t          st;
    fsp_op_t             op;
    logic [1:0]          step;
    logic [7:0]          cnt;
    logic                ceN;
    logic                oeN;
    logic                weN;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdat;
    logic [ADDR_W-1:0]   adrHeld;
    logic [DATA_W-1:0]   datHeld;
    logic                dqOe;
    logic                idHv;
    logic                rstHv;
    logic                ready;
    logic                rv;
    logic [DATA_W-1:0]   rdat;
    logic [SECT_W-1:0]   sect;
    logic                prot;
    logic [DATA_W-1:0]   s1;
    logic [DATA_W-1:0]   s2;
    logic [DATA_W-1:0]   s3;
  } fsp_host_t;

  fsp_host_t state_r;
  fsp_host_t state_nxt;

  // Sector number of an array address, bottom-boot map
  function automatic logic [SECT_W-1:0] sectorOf(input logic [ADDR_W-1:0] a);
    logic [SECT_W-1:0] s;
    s = '0;
    if (a[19:15] != 5'h0)
      s = SECT_W'(a[19:15]) + 6'h03;
    else if (a[14])
      s = 6'h03;
    else if (a[13])
      s = a[12] ? 6'h02 : 6'h01;
    else
      s = 6'h00;
    return s;
  endfunction

  // Unlock step address for in-system command prefix; step 2 gives the request address
  function automatic logic [ADDR_W-1:0] unlockAdr(input logic [1:0] k,
                                                  input logic [ADDR_W-1:0] a);
    return (k == 2'd0) ? ADDR_W'(UNLOCK_ADR1) : (k == 2'd1) ? ADDR_W'(UNLOCK_ADR2) : a;
  endfunction

  always_comb
  begin
    state_nxt    = state_r;
    state_nxt.rv = 1'b0;
    // Input pins synchronised: third and second stages must agree
    state_nxt.s1 = flashDqIn;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    case (state_r.st)
      ST_IDLE:
      begin
        state_nxt.ceN   = 1'b1;
        state_nxt.oeN   = 1'b1;
        state_nxt.weN   = 1'b1;
        state_nxt.dqOe  = 1'b0;
        // Reset-pin voltage only changes between bus cycles
        state_nxt.rstHv = reqRstHv;
        if (reqValid && state_r.ready)
        begin
          state_nxt.ready = 1'b0;
          state_nxt.op    = reqOp;
          state_nxt.addr  = (reqOp == OP_UNLOCKW) ? unlockAdr(2'd0, reqAddr) : reqAddr;
          state_nxt.wdat  = reqData;
          // Request kept aside while the unlock prefix uses the bus
          state_nxt.adrHeld = reqAddr;
          state_nxt.datHeld = reqData;
          state_nxt.sect  = sectorOf(reqAddr);
          state_nxt.step  = (reqOp == OP_UNLOCKW) ? 2'd0 : 2'd2;
          if (reqOp == OP_IDREAD)
          begin
            state_nxt.idHv = reqIdHv;
            state_nxt.addr[BIT_SEL6] = 1'b0;
          end
          state_nxt.cnt = 8'(SETUP_CYCLES);
          state_nxt.st  = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        state_nxt.ceN = 1'b0;
        if (state_r.cnt > 8'd1)
          state_nxt.cnt = state_r.cnt - 8'd1;
        else
        begin
          state_nxt.cnt = 8'(PULSE_CYCLES);
          state_nxt.st  = ST_PULSE;
          if (state_r.op == OP_WRITE || state_r.op == OP_UNLOCKW)
          begin
            state_nxt.oeN  = 1'b1;
            state_nxt.weN  = 1'b0;
            state_nxt.dqOe = 1'b1;
            state_nxt.wdat = (state_r.op == OP_UNLOCKW && state_r.step == 2'd0) ?
                             DATA_W'(UNLOCK_DAT1) :
                             (state_r.op == OP_UNLOCKW && state_r.step == 2'd1) ?
                             DATA_W'(UNLOCK_DAT2) : state_r.datHeld;
          end
          else
          begin
            // Read data must cross the pin synchroniser before it is taken
            state_nxt.oeN = 1'b0;
            state_nxt.cnt = 8'(PULSE_CYCLES + SYNC_STAGES);
          end
        end
      end
      ST_PULSE:
      begin
        if (state_r.cnt > 8'd1)
          state_nxt.cnt = state_r.cnt - 8'd1;
        else
        begin
          state_nxt.weN = 1'b1;
          state_nxt.oeN = 1'b1;
          state_nxt.st  = ST_HOLD;
          if (state_r.oeN == 1'b0 && state_r.s2 == state_r.s3)
          begin
            state_nxt.rv   = 1'b1;
            state_nxt.rdat = state_r.s3;
            state_nxt.prot = (state_r.s3[7:0] == PROT_SET);
          end
        end
      end
      ST_HOLD:
      begin
        state_nxt.dqOe = 1'b0;
        state_nxt.ceN  = 1'b1;
        state_nxt.st   = (state_r.step < 2'd2) ? ST_NEXT : ST_IDLE;
        if (state_r.step >= 2'd2)
        begin
          state_nxt.ready = 1'b1;
          state_nxt.idHv  = 1'b0;
        end
      end
      ST_NEXT:
      begin
        state_nxt.step = state_r.step + 2'd1;
        state_nxt.addr = unlockAdr(state_r.step + 2'd1, state_r.adrHeld);
        state_nxt.cnt  = 8'(SETUP_CYCLES);
        state_nxt.st   = ST_SETUP;
      end
      default:
        state_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r       <= '0;
      state_r.st    <= ST_IDLE;
      state_r.ceN   <= 1'b1;
      state_r.oeN   <= 1'b1;
      state_r.weN   <= 1'b1;
      state_r.ready <= 1'b1;
      state_r.step  <= 2'd2;
    end
    else
      state_r <= state_nxt;
  end

  assign reqReady     = state_r.ready;
  assign rspValid     = state_r.rv;
  assign rspData      = state_r.rdat;
  assign rspSector    = state_r.sect;
  assign rspProtected = state_r.prot;
  assign flashCeN     = state_r.ceN;
  assign flashOeN     = state_r.oeN;
  assign flashWeN     = state_r.weN;
  assign flashAddr    = state_r.addr;
  assign flashIdHv    = state_r.idHv;
  assign flashRstHv   = state_r.rstHv;
  assign flashDqOut   = state_r.wdat;
  assign flashDqOe    = state_r.dqOe;

  // Write cycle release: strobe rises first, select and data follow a cycle later
  sequence s_strobe_up;
    $rose(flashWeN);
  endsequence
  sequence s_deselect_after;
    !flashCeN && flashDqOe ##1 flashCeN;
  endsequence

  a_write_strobe_oe: assert property (@(posedge clock) disable iff (srst)
    !flashWeN |-> flashOeN && !flashCeN)
    else $error("write strobe low without select or with output enable");
  a_idread_sel6: assert property (@(posedge clock) disable iff (srst)
    flashIdHv |-> !flashAddr[6])
    else $error("identification read with address bit 6 high");
  a_pulse_width: assert property (@(posedge clock) disable iff (srst)
    $rose(flashWeN) |-> $past(state_r.st) == ST_PULSE && $past(state_r.cnt) == 8'd1)
    else $error("write pulse ended before its count ran out");
  a_drive_on_write: assert property (@(posedge clock) disable iff (srst)
    !flashWeN |-> flashDqOe)
    else $error("data not driven during write pulse");
  a_no_contention: assert property (@(posedge clock) disable iff (srst)
    !flashOeN |-> !flashDqOe)
    else $error("host drives data while flash output enabled");
  a_write_release: assert property (@(posedge clock) disable iff (srst)
    s_strobe_up |-> s_deselect_after)
    else $error("select or data released with the write strobe");
endmodule // fsp_host

// file: rtl/fsp_pkg.sv
// Package for the boot-sector flash protection host controller.
// Assumes a 20 MHz clock and a bottom-boot parallel flash on the far side.
package fsp_pkg;
  localparam int          ADDR_W        = 20;
  localparam int          DATA_W        = 16;
  localparam int          SECT_W        = 6;
  localparam int          SECT_COUNT    = 35;
  localparam int          CLK_MHZ       = 20;
  localparam int          SETUP_NS      = 100;
  localparam int          SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          PULSE_NS      = 100;
  localparam int          PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int          SYNC_STAGES   = 3;
  localparam logic [1:0]  ID_MAKER      = 2'b00;
  localparam logic [1:0]  ID_DEVICE     = 2'b01;
  localparam logic [1:0]  ID_PROTECT    = 2'b10;
  localparam logic [1:0]  ID_CONT       = 2'b11;
  localparam int          BIT_SEL6      = 6;
  localparam logic [7:0]  PROT_SET      = 8'h01;
  localparam logic [7:0]  PROT_CLR      = 8'h00;
  localparam logic [10:0] UNLOCK_ADR1   = 11'h555;
  localparam logic [10:0] UNLOCK_ADR2   = 11'h2AA;
  localparam logic [7:0]  UNLOCK_DAT1   = 8'hAA;
  localparam logic [7:0]  UNLOCK_DAT2   = 8'h55;

  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_WRITE   = 3'b001,
    OP_IDREAD  = 3'b010,
    OP_UNLOCKW = 3'b011
  } fsp_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_NEXT  = 3'b100
  } fsp_state_t;
endpackage

// file: tb/fsp_flash_model.sv
// Behavioural bottom-boot flash on the far side of fsp_host.
// Assumes word-mode pins; no electrical timing is modelled.
`timescale 1ns/100ps
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter logic [7:0]  MAKER = 8'h5A,   // Arbitrary value
  parameter logic [15:0] DEVID = 16'h0063, // Arbitrary value
  parameter logic [7:0]  CONTC = 8'h3C    // Arbitrary value
) (
  // Control pins
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        idHv,
  input  wire logic        rstHv,
  // Address and data
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dqIn,
  input  wire logic        dqOe,
  output logic      [15:0] dqOut
);
  logic [34:0] protFlags = '0;
  logic [1:0]  cmdSt = 2'd0;
  logic        powerUp = 1'b1;
  logic [19:0] lastAddr = '0;
  logic [15:0] lastData = '0;
  logic [15:0] relVal = '0;
  logic [15:0] outVal;
  int          wrCount = 0;
  int          protoErr = 0;
  function automatic int sectOf(input logic [19:0] a);
    if (a[19:15] != 5'd0) return int'(a[19:15]) + 3;
    if (a[14]) return 3;
    if (a[13]) return a[12] ? 2 : 1;
    return 0;
  endfunction
  initial #500 powerUp = 1'b0;
  always_comb
    if (!idHv)
      outVal = addr[15:0] ^ {addr[19:16], 12'h5A3};
    else
      case (addr[1:0])
        2'b00: outVal = {8'h00, MAKER};
        2'b01: outVal = DEVID;
        2'b11: outVal = {8'h00, CONTC};
        default: outVal = protFlags[sectOf(addr)] ? 16'h0001 : 16'h0000;
      endcase
  // Released bus shows the inverse of the last word
  always @(posedge oeN) relVal <= ~outVal;
  assign dqOut = (!ceN && !oeN) ? outVal : relVal;
  // Select may fall in the same step as the strobe; let it settle first
  always @(negedge weN)
  begin
    #1;
    if (ceN !== 1'b0 || oeN !== 1'b1) protoErr++;
  end
  always @(posedge weN)
    if (!powerUp && !ceN && oeN && dqOe)
      case (cmdSt)
        2'd0: cmdSt <= (addr[10:0] == UNLOCK_ADR1 && dqIn[7:0] == UNLOCK_DAT1) ? 2'd1 : 2'd0;
        2'd1: cmdSt <= (addr[10:0] == UNLOCK_ADR2 && dqIn[7:0] == UNLOCK_DAT2) ? 2'd2 : 2'd0;
        default:
        begin
          cmdSt <= 2'd0;
          if (!protFlags[sectOf(addr)] || rstHv)
          begin
            wrCount <= wrCount + 1;
            lastAddr <= addr;
            lastData <= dqIn;
          end
        end
      endcase
endmodule // fsp_flash_model

// file: tb/tb.sv
// Self-checking bench for fsp_host against the flash model.
// Assumes a 20 MHz clock; inputs change 2 ns after each rising edge.
`timescale 1ns/100ps
module tb;
  import fsp_pkg::*;
  typedef struct {logic [19:0] a; logic [5:0] s;} fsp_row_t;
  logic clock = 1'b0, srst = 1'b1, reqValid = 1'b0, reqIdHv = 1'b0, reqRstHv = 1'b0;
  fsp_op_t reqOp = OP_READ;
  logic [19:0] reqAddr = '0, flashAddr;
  logic [15:0] reqData = '0, rspData, flashDqOut, flashDqIn;
  logic reqReady, rspValid, rspProtected, flashCeN, flashOeN, flashWeN;
  logic flashIdHv, flashRstHv, flashDqOe;
  logic [5:0] rspSector;
  int err_count = 0, total_checks = 0;
  fsp_row_t rows [9] = '{'{20'h00000, 6'd0}, '{20'h01FFF, 6'd0}, '{20'h02000, 6'd1},
    '{20'h03000, 6'd2}, '{20'h04000, 6'd3}, '{20'h07FFF, 6'd3}, '{20'h08000, 6'd4},
    '{20'h80000, 6'd19}, '{20'hFFFFF, 6'd34}};
  logic [1:0]  idSel [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [15:0] idExp [4] = '{16'h005A, 16'h0063, 16'h003C, 16'h0001};
  wire  [15:0] wrSeen = 16'(fsp_flash_model_i.wrCount);
  always #25 clock = ~clock;
  fsp_host #(.SETUP_CYCLES(1), .PULSE_CYCLES(1)) fsp_host_i (.clock, .srst, .reqValid,
    .reqOp, .reqAddr, .reqData, .reqIdHv, .reqRstHv, .reqReady, .rspValid, .rspData,
    .rspSector, .rspProtected, .flashCeN, .flashOeN, .flashWeN, .flashAddr, .flashIdHv,
    .flashRstHv, .flashDqOut, .flashDqOe, .flashDqIn);
  fsp_flash_model fsp_flash_model_i (.ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
    .idHv(flashIdHv), .rstHv(flashRstHv), .addr(flashAddr), .dqIn(flashDqOut),
    .dqOe(flashDqOe), .dqOut(flashDqIn));
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitHi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1)
    begin
      @(posedge clock);
      #2;
      n++;
      if (n > 60)
      begin
        err_count++;
        results();
      end
    end
  endtask
  task automatic doReq(input fsp_op_t op, input logic [19:0] a, input logic [15:0] d,
                       input logic hv);
    waitHi(reqReady);
    reqOp = op;
    reqAddr = a;
    reqData = d;
    reqIdHv = hv;
    reqValid = 1'b1;
    @(posedge clock);
    #2;
    reqValid = 1'b0;
    if (op == OP_READ || op == OP_IDREAD)
      waitHi(rspValid);
    else
      waitHi(reqReady);
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    #2;
    srst = 1'b0;
    chk({12'h000, flashCeN, flashOeN, flashWeN, flashDqOe}, 16'h000E);
    foreach (rows[i])
    begin
      doReq(OP_READ, rows[i].a, 16'h0000, 1'b0);
      chk(rspData, rows[i].a[15:0] ^ {rows[i].a[19:16], 12'h5A3});
      chk({10'h000, rspSector}, {10'h000, rows[i].s});
    end
    doReq(OP_IDREAD, 20'h10002, 16'h0000, 1'b1);
    chk(rspData, 16'h0000);
    fsp_flash_model_i.protFlags[5] = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      doReq(OP_IDREAD, {18'h04000, idSel[k]}, 16'h0000, 1'b1);
      chk(rspData, idExp[k]);
    end
    chk({15'h0000, rspProtected}, 16'h0001);
    doReq(OP_UNLOCKW, 20'h00123, 16'hBEEF, 1'b0);
    chk(fsp_flash_model_i.lastData, 16'hBEEF);
    doReq(OP_WRITE, 20'h00124, 16'h1111, 1'b0);
    chk(wrSeen, 16'h0001);
    doReq(OP_UNLOCKW, 20'h10040, 16'h2222, 1'b0);
    chk(wrSeen, 16'h0001);
    reqRstHv = 1'b1;
    doReq(OP_UNLOCKW, 20'h10040, 16'h3333, 1'b0);
    chk(wrSeen, 16'h0002);
    reqRstHv = 1'b0;
    doReq(OP_UNLOCKW, 20'h10048, 16'h5555, 1'b0);
    chk(wrSeen, 16'h0002);
    fsp_flash_model_i.protFlags[5] = 1'b0;
    doReq(OP_UNLOCKW, 20'h10044, 16'h4444, 1'b0);
    chk(fsp_flash_model_i.lastAddr[15:0], 16'h0044);
    chk(16'(fsp_flash_model_i.protoErr), 16'h0000);
    results();
  end
endmodule // tb
